// [common/mds_pkg.sv]
// =====================================================================
// Shared constants of the multiply, divide, clamp and field unit.
package mds_pkg;
  localparam int DATA_W = 32;
  localparam logic [31:0] RST_WORD = 32'h0000_0000;
  // Register byte addresses on the Avalon-MM slave.
  localparam logic [5:0] OFS_CTRL = 6'h00;
  localparam logic [5:0] OFS_OPA = 6'h04;
  localparam logic [5:0] OFS_OPB = 6'h08;
  localparam logic [5:0] OFS_OPC = 6'h0c;
  localparam logic [5:0] OFS_ACC_HI = 6'h10;
  localparam logic [5:0] OFS_SAT_CFG = 6'h14;
  localparam logic [5:0] OFS_FIELD_CFG = 6'h18;
  localparam logic [5:0] OFS_RES_LO = 6'h1c;
  localparam logic [5:0] OFS_RES_HI = 6'h20;
  localparam logic [5:0] OFS_STATUS = 6'h24;
  // Control word fields.
  localparam int CTRL_OP_LSB = 0;
  localparam int CTRL_FLAGS_BIT = 4;
  localparam int CTRL_DGIVEN_BIT = 5;
  localparam int CTRL_DEST_LSB = 6;
  localparam int CTRL_SRC1_LSB = 10;
  localparam int CTRL_START_BIT = 31;
  // Clamp and field configuration fields.
  localparam int SAT_SHIFT_LSB = 0;
  localparam int SAT_ASR_BIT = 5;
  localparam int SAT_N_LSB = 8;
  localparam int FLD_LSB_LSB = 0;
  localparam int FLD_WIDTH_LSB = 8;
  // Status word fields.
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_DEST_LSB = 4;
  localparam int STAT_Q_BIT = 27;
  localparam int STAT_V_BIT = 28;
  localparam int STAT_C_BIT = 29;
  localparam int STAT_Z_BIT = 30;
  localparam int STAT_N_BIT = 31;
  typedef enum logic [3:0] {
    PRODUCT_LOW_WORD = 4'h0, PRODUCT_PLUS_ADDEND = 4'h1, ADDEND_MINUS_PRODUCT = 4'h2,
    UNSIGNED_WIDE_PRODUCT = 4'h3, UNSIGNED_WIDE_ACCUMULATE = 4'h4, SIGNED_WIDE_PRODUCT = 4'h5,
    SIGNED_WIDE_ACCUMULATE = 4'h6, SIGNED_QUOTIENT = 4'h7, UNSIGNED_QUOTIENT = 4'h8,
    SIGNED_CLAMP = 4'h9, UNSIGNED_CLAMP = 4'ha, FIELD_ZEROING = 4'hb, FIELD_INSERTION = 4'hc
  } mds_op_e;
endpackage

// [common/mds_div_if.sv]
`timescale 1ns/1ns
// =====================================================================
// Request and answer between the core sequencer and the divider.
interface mds_div_if;
  logic req;
  logic signed_op;
  logic [31:0] dividend;
  logic [31:0] divisor;
  logic done;
  logic [31:0] quotient;
  modport core (output req, signed_op, dividend, divisor, input done, quotient);
  modport div (input req, signed_op, dividend, divisor, output done, quotient);
endinterface

// [design/mds_satfield.sv]
`timescale 1ns/1ns
// =====================================================================
// Shift-then-clamp and field clear or insert, purely combinational.
module mds_satfield (
  input wire logic [3:0] op,
  input wire logic [31:0] src,
  input wire logic [31:0] dst_old,
  input wire logic [4:0] shift_amt,
  input wire logic shift_asr,
  input wire logic [5:0] sat_n,
  input wire logic [4:0] f_lsb,
  input wire logic [5:0] f_width,
  output logic [31:0] result,
  output logic saturated
);
  logic [31:0] shv;
  logic signed [32:0] x;
  logic signed [32:0] hi;
  logic signed [32:0] lo;
  logic signed [32:0] cl;
  logic [31:0] mask;

  // The shift is done at word width, so left-shifted bits are lost first.
  always_comb
  begin
    shv = shift_asr ? 32'($signed(src) >>> shift_amt) : (src << shift_amt); // RL18
    x = $signed({shv[31], shv});
    if (op == mds_pkg::SIGNED_CLAMP)
    begin
      hi = (33'sd1 <<< 6'(sat_n - 6'd1)) - 33'sd1; // RL16
      lo = ~hi;
    end
    else
    begin
      hi = (33'sd1 <<< sat_n) - 33'sd1; // RL17
      lo = 33'sd0;
    end
    if (x > hi)
      cl = hi;
    else if (x < lo)
      cl = lo;
    else
      cl = x;
    saturated = (cl != x); // RL19
    mask = 32'(((64'h1 << f_width) - 64'h1) << f_lsb);
    if (op == mds_pkg::FIELD_ZEROING)
      result = dst_old & ~mask; // RL20
    else if (op == mds_pkg::FIELD_INSERTION)
      result = (dst_old & ~mask) | ((src << f_lsb) & mask); // RL22
    else
      result = cl[31:0];
  end
endmodule

// [design/mds_divider.sv]
`timescale 1ns/1ns
// =====================================================================
// Restoring divider, one quotient bit per cycle on magnitudes.
module mds_divider (
  input wire logic core_clk,
  input wire logic rst,
  mds_div_if.div dv
);
  localparam int W = mds_pkg::DATA_W;
  localparam int CW = $clog2(W + 1);
  typedef struct packed {
    logic busy;
    logic [CW-1:0] cnt;
    logic neg;
    logic zero;
    logic [W:0] rem;
    logic [W-1:0] quo;
    logic [W-1:0] dsr;
    logic [W-1:0] dvd;
    logic done;
    logic [W-1:0] q_out;
  } mds_div_s;
  mds_div_s r;
  mds_div_s n;
  logic [W:0] shifted;
  logic [W:0] diff;
  logic [W-1:0] step_quo;
  logic [W:0] step_rem;

  assign dv.done = r.done;
  assign dv.quotient = r.q_out;

  // Magnitudes are divided, the sign is put back at the end.
  always_comb
  begin
    n = r;
    n.done = 1'b0;
    shifted = {r.rem[W-1:0], r.quo[W-1]};
    diff = shifted - {1'b0, r.dsr};
    step_rem = diff[W] ? shifted : diff;
    step_quo = {r.quo[W-2:0], ~diff[W]};
    if (dv.req && !r.busy)
    begin
      n.busy = 1'b1;
      n.cnt = CW'(W);
      n.neg = dv.signed_op & (dv.dividend[W-1] ^ dv.divisor[W-1]); // RL12
      n.zero = (dv.divisor == '0);
      n.rem = '0;
      n.quo = (dv.signed_op & dv.dividend[W-1]) ? -dv.dividend : dv.dividend; // RL13
      n.dsr = (dv.signed_op & dv.divisor[W-1]) ? -dv.divisor : dv.divisor;
      n.dvd = n.quo;
    end
    else if (r.busy)
    begin
      n.rem = step_rem;
      n.quo = step_quo;
      n.cnt = r.cnt - CW'(1);
      if (r.cnt == CW'(1))
      begin
        n.busy = 1'b0;
        n.done = 1'b1;
        // Negating a magnitude quotient keeps truncation toward zero.
        n.q_out = r.zero ? '0 : (r.neg ? -step_quo : step_quo); // RL14 RL23
      end
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
      r <= '0;
    else
      r <= n;
  end

  a_div_trunc: assert property (@(posedge core_clk) disable iff (rst) // RL14
    (r.done && !r.zero) |-> ((64'(r.quo) * r.dsr + r.rem == 64'(r.dvd)) && (r.rem < r.dsr)))
    else $error("divider magnitude quotient not truncated");
endmodule

// [design/mds_unit.sv]
// Chosen here: the register addresses and the Avalon-MM interface to the registers.
`timescale 1ns/1ns
// How it works
// [RL1] Plain multiply keeps low 32 product bits.
// [RL2] Product plus addend, low 32 bits.
// [RL3] Addend minus product, low 32 bits.
// [RL4] Short multiplies ignore operand signedness.
// [RL5] Missing destination means first source register.
// [RL6] Flagged multiply sets N, Z only.
// [RL7] Flagged multiply uses low registers, unpredicated.
// [RL8] Unsigned wide product split low/high.
// [RL9] Unsigned wide product added to pair.
// [RL10] Signed wide product split low/high.
// [RL11] Signed wide product added to pair.
// [RL12] Signed division of first by second.
// [RL13] Unsigned division of first by second.
// [RL14] Inexact quotients truncate toward zero.
// [RL15] Divisions leave all flags alone.
// [RL16] Signed clamp after shift, n 1..32.
// [RL17] Unsigned clamp after shift, n 0..31.
// [RL18] Optional arithmetic right or logical left shift.
// [RL19] Clamp sets sticky Q; only status write clears.
// [RL20] Field zeroing clears width bits at lsb.
// [RL21] Field lsb 0..31, width 1..32-lsb.
// [RL22] Field insertion copies low source bits.
// [RL23] Divide by zero gives zero quotient.
module mds_unit (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [5:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output logic busy
);
  // ===================================================================
  // State.
  typedef enum logic [1:0] {
    MDS_IDLE = 2'b00,
    MDS_EXEC = 2'b01,
    MDS_DIVW = 2'b11
  } mds_state_e;

  typedef struct packed {
    mds_state_e st;
    logic ack;
    logic [31:0] rdata;
    mds_pkg::mds_op_e op;
    logic set_flags;
    logic dest_given;
    logic [3:0] dest_idx;
    logic [3:0] src1_idx;
    logic [31:0] opa;
    logic [31:0] opb;
    logic [31:0] opc;
    logic [31:0] acc_hi;
    logic [4:0] shift_amt;
    logic shift_asr;
    logic [5:0] sat_n;
    logic [4:0] f_lsb;
    logic [5:0] f_width;
    logic [31:0] res_lo;
    logic [31:0] res_hi;
    logic [3:0] res_dest;
    logic fn;
    logic fz;
    logic fc;
    logic fv;
    logic fq;
    logic div_req;
  } mds_core_s;

  mds_core_s r;
  mds_core_s n;
  logic [31:0] rd_mux;
  logic [63:0] prod_u;
  logic [63:0] prod_s;
  logic [63:0] acc;
  logic [31:0] sf_result;
  logic sf_sat;
  logic wr_hit;
  logic [3:0] short_dest;
  mds_div_if dv ();

  // ===================================================================
  // Datapath helpers.
  mds_satfield u_satfield (
    .op(r.op),
    .src(r.opa),
    .dst_old(r.opc),
    .shift_amt(r.shift_amt),
    .shift_asr(r.shift_asr),
    .sat_n(r.sat_n),
    .f_lsb(r.f_lsb),
    .f_width(r.f_width),
    .result(sf_result),
    .saturated(sf_sat)
  );

  mds_divider u_divider (
    .core_clk(core_clk),
    .rst(rst),
    .dv(dv.div)
  );

  // The divider latches its operands on the request, so later writes are harmless.
  assign dv.req = r.div_req;
  assign dv.signed_op = (r.op == mds_pkg::SIGNED_QUOTIENT);
  assign dv.dividend = r.opa;
  assign dv.divisor = r.opb;

  // Sign-extended operands give the signed product in the low 64 bits,
  // and the low word of both products is the same bit pattern.
  assign prod_u = {32'h0, r.opa} * {32'h0, r.opb}; // RL8
  assign prod_s = {{32{r.opa[31]}}, r.opa} * {{32{r.opb[31]}}, r.opb}; // RL10
  assign acc = {r.acc_hi, r.opc};
  assign short_dest = r.dest_given ? r.dest_idx : r.src1_idx; // RL5

  // ===================================================================
  // Bus answers: one wait cycle per access, read data from a flop.
  assign avs_waitrequest = ~r.ack;
  assign avs_readdata = r.rdata;
  assign busy = (r.st != MDS_IDLE);
  assign wr_hit = avs_write & r.ack;

  // Read multiplexer; unmapped addresses read as zero.
  always_comb
  begin
    case (avs_address)
      mds_pkg::OFS_CTRL:
        rd_mux = {18'h0, r.src1_idx, r.dest_idx, r.dest_given, r.set_flags, r.op};
      mds_pkg::OFS_OPA: rd_mux = r.opa;
      mds_pkg::OFS_OPB: rd_mux = r.opb;
      mds_pkg::OFS_OPC: rd_mux = r.opc;
      mds_pkg::OFS_ACC_HI: rd_mux = r.acc_hi;
      mds_pkg::OFS_SAT_CFG: rd_mux = {18'h0, r.sat_n, 2'h0, r.shift_asr, r.shift_amt};
      mds_pkg::OFS_FIELD_CFG: rd_mux = {18'h0, r.f_width, 3'h0, r.f_lsb};
      mds_pkg::OFS_RES_LO: rd_mux = r.res_lo;
      mds_pkg::OFS_RES_HI: rd_mux = r.res_hi;
      mds_pkg::OFS_STATUS:
        rd_mux = {r.fn, r.fz, r.fc, r.fv, r.fq, 19'h0, r.res_dest, 3'h0, busy};
      default: rd_mux = mds_pkg::RST_WORD;
    endcase
  end

  // ===================================================================
  // Next state: register writes first, then the sequencer, so that a
  // hardware flag event in the same cycle overrides a software write.
  always_comb
  begin
    n = r;
    n.div_req = 1'b0;
    n.ack = (avs_read | avs_write) & ~r.ack;
    if (avs_read && !r.ack)
      n.rdata = rd_mux;
    if (wr_hit)
    begin
      case (avs_address)
        mds_pkg::OFS_CTRL:
        begin
          // A write while busy is dropped whole; the start and the field updates alike.
          n.op = mds_pkg::mds_op_e'(avs_writedata[mds_pkg::CTRL_OP_LSB +: 4]);
          n.set_flags = avs_writedata[mds_pkg::CTRL_FLAGS_BIT];
          n.dest_given = avs_writedata[mds_pkg::CTRL_DGIVEN_BIT];
          n.dest_idx = avs_writedata[mds_pkg::CTRL_DEST_LSB +: 4];
          n.src1_idx = avs_writedata[mds_pkg::CTRL_SRC1_LSB +: 4];
          if (avs_writedata[mds_pkg::CTRL_START_BIT] && r.st == MDS_IDLE)
            n.st = MDS_EXEC;
          if (r.st != MDS_IDLE)
          begin
            n.op = r.op;
            n.set_flags = r.set_flags;
            n.dest_given = r.dest_given;
            n.dest_idx = r.dest_idx;
            n.src1_idx = r.src1_idx;
          end
        end
        mds_pkg::OFS_OPA: n.opa = avs_writedata;
        mds_pkg::OFS_OPB: n.opb = avs_writedata;
        mds_pkg::OFS_OPC: n.opc = avs_writedata;
        mds_pkg::OFS_ACC_HI: n.acc_hi = avs_writedata;
        mds_pkg::OFS_SAT_CFG:
        begin
          n.shift_amt = avs_writedata[mds_pkg::SAT_SHIFT_LSB +: 5];
          n.shift_asr = avs_writedata[mds_pkg::SAT_ASR_BIT];
          n.sat_n = avs_writedata[mds_pkg::SAT_N_LSB +: 6];
        end
        mds_pkg::OFS_FIELD_CFG:
        begin
          n.f_lsb = avs_writedata[mds_pkg::FLD_LSB_LSB +: 5]; // RL21
          n.f_width = avs_writedata[mds_pkg::FLD_WIDTH_LSB +: 6];
        end
        mds_pkg::OFS_STATUS:
        begin
          n.fn = avs_writedata[mds_pkg::STAT_N_BIT];
          n.fz = avs_writedata[mds_pkg::STAT_Z_BIT];
          n.fc = avs_writedata[mds_pkg::STAT_C_BIT];
          n.fv = avs_writedata[mds_pkg::STAT_V_BIT];
          n.fq = avs_writedata[mds_pkg::STAT_Q_BIT]; // RL19
        end
        default:
        begin
        end
      endcase
    end
    unique case (r.st)
      MDS_IDLE:
      begin
      end
      MDS_EXEC:
      begin
        n.st = MDS_IDLE;
        n.res_dest = r.dest_idx;
        case (r.op)
          mds_pkg::PRODUCT_LOW_WORD:
          begin
            n.res_lo = prod_u[31:0]; // RL1 RL4
            n.res_dest = short_dest; // RL5
            // Register-number limits of the flagged form are the issuer's job.
            if (r.set_flags) // RL7
            begin
              n.fn = prod_u[31]; // RL6
              n.fz = (prod_u[31:0] == 32'h0);
            end
          end
          mds_pkg::PRODUCT_PLUS_ADDEND: n.res_lo = r.opc + prod_u[31:0]; // RL2
          mds_pkg::ADDEND_MINUS_PRODUCT: n.res_lo = r.opc - prod_u[31:0]; // RL3
          mds_pkg::UNSIGNED_WIDE_PRODUCT: {n.res_hi, n.res_lo} = prod_u; // RL8
          mds_pkg::UNSIGNED_WIDE_ACCUMULATE: {n.res_hi, n.res_lo} = prod_u + acc; // RL9
          mds_pkg::SIGNED_WIDE_PRODUCT: {n.res_hi, n.res_lo} = prod_s; // RL10
          mds_pkg::SIGNED_WIDE_ACCUMULATE: {n.res_hi, n.res_lo} = prod_s + acc; // RL11
          mds_pkg::SIGNED_QUOTIENT, mds_pkg::UNSIGNED_QUOTIENT:
          begin
            n.div_req = 1'b1;
            n.st = MDS_DIVW;
          end
          mds_pkg::SIGNED_CLAMP, mds_pkg::UNSIGNED_CLAMP:
          begin
            n.res_lo = sf_result; // RL16 RL17
            if (sf_sat)
              n.fq = 1'b1; // RL19
          end
          mds_pkg::FIELD_ZEROING, mds_pkg::FIELD_INSERTION: n.res_lo = sf_result; // RL20 RL22
          default:
            n.res_dest = r.res_dest;
        endcase
      end
      MDS_DIVW:
      begin
        // Flags are never touched on the division path.
        if (dv.done) // RL15
        begin
          n.res_lo = dv.quotient; // RL12 RL13 RL23
          n.res_dest = short_dest; // RL5
          n.st = MDS_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
      r <= '0;
    else
      r <= n;
  end

  // ===================================================================
  // Checks.
  a_mul_low_word: assert property (@(posedge core_clk) disable iff (rst) // RL1
    (r.st == MDS_EXEC && r.op == mds_pkg::PRODUCT_LOW_WORD)
    |=> (r.res_lo == 32'($past(r.opa) * $past(r.opb))))
    else $error("multiply low word wrong");

  a_mul_dest: assert property (@(posedge core_clk) disable iff (rst) // RL5
    (r.st == MDS_EXEC && r.op == mds_pkg::PRODUCT_LOW_WORD && !r.dest_given)
    |=> (r.res_dest == $past(r.src1_idx)))
    else $error("default destination wrong");

  a_mla_sum: assert property (@(posedge core_clk) disable iff (rst) // RL2
    (r.st == MDS_EXEC && r.op == mds_pkg::PRODUCT_PLUS_ADDEND)
    |=> (r.res_lo == 32'($past(r.opa) * $past(r.opb) + $past(r.opc))))
    else $error("multiply-add result wrong");

  a_mls_diff: assert property (@(posedge core_clk) disable iff (rst) // RL3
    (r.st == MDS_EXEC && r.op == mds_pkg::ADDEND_MINUS_PRODUCT)
    |=> (r.res_lo == 32'($past(r.opc) - $past(r.opa) * $past(r.opb))))
    else $error("multiply-subtract result wrong");

  a_sign_free: assert property (@(posedge core_clk) disable iff (rst) // RL4
    (r.st == MDS_EXEC) |-> (prod_u[31:0] == prod_s[31:0]))
    else $error("short product depends on signedness");

  a_mul_flags: assert property (@(posedge core_clk) disable iff (rst) // RL6
    (r.st == MDS_EXEC && r.op == mds_pkg::PRODUCT_LOW_WORD && r.set_flags && !wr_hit)
    |=> (r.fn == r.res_lo[31]) && (r.fz == (r.res_lo == 32'h0)) && $stable(r.fc)
        && $stable(r.fv))
    else $error("flagged multiply flags wrong");

  a_unsigned_wide_product_pair: assert property (@(posedge core_clk) disable iff (rst) // RL8
    (r.st == MDS_EXEC && r.op == mds_pkg::UNSIGNED_WIDE_PRODUCT)
    |=> ({r.res_hi, r.res_lo} == 64'($past(r.opa)) * 64'($past(r.opb))))
    else $error("unsigned wide product wrong");

  a_unsigned_wide_accumulate_pair: assert property (@(posedge core_clk) disable iff (rst) // RL9
    (r.st == MDS_EXEC && r.op == mds_pkg::UNSIGNED_WIDE_ACCUMULATE)
    |=> ({r.res_hi, r.res_lo} == $past(prod_u) + {$past(r.acc_hi), $past(r.opc)}))
    else $error("unsigned wide accumulate wrong");

  a_signed_wide_product_pair: assert property (@(posedge core_clk) disable iff (rst) // RL10
    (r.st == MDS_EXEC && r.op == mds_pkg::SIGNED_WIDE_PRODUCT)
    |=> ($signed({r.res_hi, r.res_lo}) == $signed($past(r.opa)) * $signed($past(r.opb))))
    else $error("signed wide product wrong");

  a_signed_wide_accumulate_pair: assert property (@(posedge core_clk) disable iff (rst) // RL11
    (r.st == MDS_EXEC && r.op == mds_pkg::SIGNED_WIDE_ACCUMULATE)
    |=> ({r.res_hi, r.res_lo}
        == 64'($signed($past(r.opa)) * $signed($past(r.opb))) + {$past(r.acc_hi), $past(r.opc)}))
    else $error("signed wide accumulate wrong");

  a_div_zero: assert property (@(posedge core_clk) disable iff (rst) // RL23
    (r.st == MDS_EXEC && r.op == mds_pkg::UNSIGNED_QUOTIENT && r.opb == 32'h0)
    |=> ##[1:40] (r.st == MDS_IDLE && r.res_lo == 32'h0))
    else $error("divide by zero not answered with zero");

  a_div_flags: assert property (@(posedge core_clk) disable iff (rst) // RL15
    (r.st == MDS_DIVW && !wr_hit)
    |=> $stable({r.fn, r.fz, r.fc, r.fv, r.fq}))
    else $error("division changed the flags");

  a_q_sticky: assert property (@(posedge core_clk) disable iff (rst) // RL19
    (r.fq && !(wr_hit && avs_address == mds_pkg::OFS_STATUS)) |=> r.fq)
    else $error("sticky saturation flag dropped");

  a_q_on_sat: assert property (@(posedge core_clk) disable iff (rst) // RL19
    (r.st == MDS_EXEC && sf_sat
     && (r.op == mds_pkg::SIGNED_CLAMP || r.op == mds_pkg::UNSIGNED_CLAMP))
    |=> r.fq)
    else $error("saturation did not set the flag");
endmodule

// [verif/mds_host_model.sv]
`timescale 1ns/1ns
// =====================================================================
// Avalon-MM master standing in for the instruction source.
module mds_host_model (
  input wire logic core_clk,
  input wire logic avs_waitrequest,
  input wire logic [31:0] avs_readdata,
  output logic [5:0] avs_address,
  output logic avs_read,
  output logic avs_write,
  output logic [31:0] avs_writedata
);
  // The bus starts idle so nothing is requested while reset is held.
  initial
  begin
    avs_address = 6'h00;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0000_0000;
  end

  // One access; the request stands until waitrequest is sampled low.
  // There is no local bound, so only the bench watchdog ends a stall.
  task automatic access(input logic wr, input logic [5:0] a, input logic [31:0] d,
                        output logic [31:0] q);
    @(posedge core_clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_read <= !wr;
    avs_write <= wr;
    @(posedge core_clk);
    while (avs_waitrequest !== 1'b0)
      @(posedge core_clk);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
endmodule

// [verif/tb.sv]
`timescale 1ns/1ns
// =====================================================================
// Self-checking bench for the multiply, divide, clamp and field unit.
module tb;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic [5:0] avs_address;
  logic avs_read;
  logic avs_write;
  logic [31:0] avs_writedata;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic busy;
  logic [31:0] rdat;
  int fails = 0;
  int num_checks = 0;

  // The core clock runs at 100 MHz.
  always #5 core_clk = ~core_clk;

  mds_unit dut (.core_clk(core_clk), .rst(rst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .busy(busy));

  mds_host_model host (.core_clk(core_clk), .avs_waitrequest(avs_waitrequest),
    .avs_readdata(avs_readdata), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata));

  // =====================================================================
  // Bus helpers.
  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    host.access(1'b1, a, d, rdat);
  endtask

  // Reads a register and compares only the bits chosen by the mask.
  task automatic rd_chk(input logic [5:0] a, input logic [31:0] e, input logic [31:0] m);
    host.access(1'b0, a, 32'h0, rdat);
    num_checks++;
    if ((rdat & m) !== (e & m))
    begin
      fails++;
      $display("mismatch at %0t: addr %h got %h expected %h", $time, a, rdat, e);
    end
  endtask

  function automatic logic [30:0] cw(input logic [3:0] op, input logic f, input logic dg,
                                     input logic [3:0] dst, input logic [3:0] src);
    return {17'h0, src, dst, dg, f, op};
  endfunction

  // Compares the busy output with the level it must show.
  task automatic chk_busy(input logic e);
    num_checks++;
    if (busy !== e)
    begin
      fails++;
      $display("mismatch at %0t: busy %b expected %b", $time, busy, e);
    end
  endtask

  // Starts an operation, sees the busy output up in the cycle after the start
  // lands, polls the busy bit until it clears and sees the output drop too.
  task automatic exec(input logic [30:0] c);
    wr(mds_pkg::OFS_CTRL, {1'b1, c});
    @(posedge core_clk);
    chk_busy(1'b1);
    rdat = 32'h1;
    while (rdat[0] !== 1'b0)
      host.access(1'b0, mds_pkg::OFS_STATUS, 32'h0, rdat);
    chk_busy(1'b0);
  endtask

  task automatic load(input logic [31:0] a, input logic [31:0] b, input logic [31:0] c,
                      input logic [31:0] h);
    wr(mds_pkg::OFS_OPA, a);
    wr(mds_pkg::OFS_OPB, b);
    wr(mds_pkg::OFS_OPC, c);
    wr(mds_pkg::OFS_ACC_HI, h);
  endtask

  // =====================================================================
  // Scenarios.
  // Reset values, unmapped places and the write-only start bit.
  task automatic t_misc();
    rd_chk(mds_pkg::OFS_STATUS, 32'h0, '1);
    rd_chk(mds_pkg::OFS_RES_LO, 32'h0, '1);
    wr(6'h28, 32'hffff_ffff);
    rd_chk(6'h28, 32'h0, '1);
    rd_chk(6'h02, 32'h0, '1);
    rd_chk(mds_pkg::OFS_CTRL, 32'h0, 32'h8000_0000);
  endtask

  // Short products; the preset C and V must survive flag updates.
  task automatic t_short();
    logic [31:0] a, b, c, e;
    a = 32'h0001_0003;
    b = 32'hfffe_0005;
    c = 32'h1234_5678;
    e = a * b;
    load(a, b, c, 32'h0);
    wr(mds_pkg::OFS_STATUS, 32'h3000_0000);
    exec(cw(mds_pkg::PRODUCT_LOW_WORD, 1'b1, 1'b1, 4'h2, 4'h1));
    rd_chk(mds_pkg::OFS_RES_LO, e, '1);
    rd_chk(mds_pkg::OFS_STATUS, {e[31], e == 32'h0, 3'b110, 19'h0, 8'h20}, 32'hf800_00f0);
    // A product of exactly 2^32 leaves a zero low word.
    wr(mds_pkg::OFS_OPA, 32'h0001_0000);
    wr(mds_pkg::OFS_OPB, 32'h0001_0000);
    exec(cw(mds_pkg::PRODUCT_LOW_WORD, 1'b1, 1'b1, 4'h2, 4'h1));
    rd_chk(mds_pkg::OFS_STATUS, 32'h7000_0020, 32'hf800_00f0);
    exec(cw(mds_pkg::PRODUCT_LOW_WORD, 1'b0, 1'b0, 4'h0, 4'hc));
    rd_chk(mds_pkg::OFS_STATUS, 32'h7000_00c0, 32'hf800_00f0);
    rd_chk(mds_pkg::OFS_RES_LO, 32'h0, '1);
    wr(mds_pkg::OFS_OPA, a);
    wr(mds_pkg::OFS_OPB, b);
    exec(cw(mds_pkg::PRODUCT_PLUS_ADDEND, 1'b0, 1'b1, 4'ha, 4'h1));
    rd_chk(mds_pkg::OFS_RES_LO, a * b + c, '1);
    rd_chk(mds_pkg::OFS_STATUS, 32'h0000_00a0, 32'h0000_00f0);
    exec(cw(mds_pkg::ADDEND_MINUS_PRODUCT, 1'b0, 1'b1, 4'hb, 4'h1));
    rd_chk(mds_pkg::OFS_RES_LO, c - a * b, '1);
  endtask

  // Wide products; the accumulator carries from the low into the high word.
  task automatic t_wide();
    logic [31:0] a, b;
    logic [63:0] u, s, acc, e;
    a = 32'hffff_fff0;
    b = 32'h8000_0003;
    acc = 64'h0000_0001_ffff_fff0;
    u = {32'h0, a} * {32'h0, b};
    s = {{32{a[31]}}, a} * {{32{b[31]}}, b};
    for (int i = 0; i < 4; i++)
    begin
      e = (i == 0) ? u : (i == 1) ? u + acc : (i == 2) ? s : s + acc;
      load(a, b, acc[31:0], acc[63:32]);
      exec(cw(4'(4'h3 + i), 1'b0, 1'b1, 4'h4, 4'h5));
      rd_chk(mds_pkg::OFS_RES_LO, e[31:0], '1);
      rd_chk(mds_pkg::OFS_RES_HI, e[63:32], '1);
    end
  endtask

  // Divides with every flag preset; quotients truncate toward zero.
  task automatic t_div();
    logic [31:0] n [6] = '{32'hffff_fff9, 32'h7, 32'hffff_fff9, 32'h5, 32'h8000_0000, 32'h64};
    logic [31:0] d [6] = '{32'h2, 32'hffff_fffe, 32'h2, 32'h0, 32'hffff_ffff, 32'h0};
    bit sg [6] = '{1, 1, 0, 1, 1, 0};
    logic signed [63:0] sn, sd, q;
    logic [31:0] e;
    wr(mds_pkg::OFS_STATUS, 32'hf800_0000);
    for (int i = 0; i < 6; i++)
    begin
      sn = {{32{n[i][31]}}, n[i]};
      sd = {{32{d[i][31]}}, d[i]};
      q = (d[i] == 32'h0) ? 64'sh0 : sn / sd;
      e = (d[i] == 32'h0) ? 32'h0 : sg[i] ? q[31:0] : n[i] / d[i];
      load(n[i], d[i], 32'h0, 32'h0);
      exec(cw(sg[i] ? mds_pkg::SIGNED_QUOTIENT : mds_pkg::UNSIGNED_QUOTIENT,
              1'b0, 1'b0, 4'h0, 4'h5));
      rd_chk(mds_pkg::OFS_RES_LO, e, '1);
      rd_chk(mds_pkg::OFS_STATUS, 32'hf800_0050, 32'hf800_00f0);
    end
  endtask

  // Clamps at the range edges; the saturation flag stays set until written.
  task automatic t_clamp();
    logic [31:0] x [6] = '{32'h8000_0000, 32'h1234, 32'h0, 32'hffff_fff0, 32'hffff_ff00, 32'hff};
    bit sg [6] = '{1, 1, 0, 0, 1, 0};
    bit asr [6] = '{0, 0, 0, 1, 1, 0};
    logic [4:0] sh [6] = '{5'd0, 5'd4, 5'd0, 5'd2, 5'd31, 5'd1};
    logic [5:0] n [6] = '{6'd32, 6'd16, 6'd0, 6'd7, 6'd1, 6'd8};
    longint v, lo, hi, r;
    logic qs;
    qs = 1'b0;
    wr(mds_pkg::OFS_STATUS, 32'h0);
    for (int i = 0; i < 6; i++)
    begin
      v = asr[i] ? longint'($signed(x[i]) >>> sh[i]) : longint'($signed(x[i] << sh[i]));
      lo = sg[i] ? -(64'sd1 <<< (n[i] - 1)) : 64'sd0;
      hi = sg[i] ? (64'sd1 <<< (n[i] - 1)) - 1 : (64'sd1 <<< n[i]) - 1;
      r = (v < lo) ? lo : (v > hi) ? hi : v;
      qs = qs | (r != v);
      wr(mds_pkg::OFS_OPA, x[i]);
      wr(mds_pkg::OFS_SAT_CFG, {18'h0, n[i], 2'b00, asr[i], sh[i]});
      exec(cw(sg[i] ? mds_pkg::SIGNED_CLAMP : mds_pkg::UNSIGNED_CLAMP, 1'b0, 1'b1, 4'h7, 4'h1));
      rd_chk(mds_pkg::OFS_RES_LO, 32'(r), '1);
      rd_chk(mds_pkg::OFS_STATUS, {4'h0, qs, 27'h0}, 32'h0800_0000);
    end
    wr(mds_pkg::OFS_STATUS, 32'h0);
    rd_chk(mds_pkg::OFS_STATUS, 32'h0, 32'h0800_0000);
  endtask

  // Field clear and insert at a middle, the full and the topmost placement.
  task automatic t_field();
    logic [4:0] l [3] = '{5'd8, 5'd0, 5'd31};
    logic [5:0] w [3] = '{6'd12, 6'd32, 6'd1};
    logic [31:0] old, src, m;
    old = 32'h5a5a_c3c3;
    src = 32'h0123_4567;
    for (int i = 0; i < 3; i++)
    begin
      m = 32'(((64'h1 << w[i]) - 64'h1) << l[i]);
      load(src, 32'h0, old, 32'h0);
      wr(mds_pkg::OFS_FIELD_CFG, {18'h0, w[i], 3'h0, l[i]});
      exec(cw(mds_pkg::FIELD_ZEROING, 1'b0, 1'b1, 4'h6, 4'h1));
      rd_chk(mds_pkg::OFS_RES_LO, old & ~m, '1);
      exec(cw(mds_pkg::FIELD_INSERTION, 1'b0, 1'b1, 4'h6, 4'h1));
      rd_chk(mds_pkg::OFS_RES_LO, (old & ~m) | ((src << l[i]) & m), '1);
    end
  endtask

  // =====================================================================
  // Verdict, reached from the main sequence or from the watchdog.
  task automatic complete_run();
    $display("checks %0d, mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // Main sequence after three cycles of reset.
  initial
  begin
    repeat (3) @(posedge core_clk);
    rst <= 1'b0;
    t_misc();
    t_short();
    t_wide();
    t_div();
    t_clamp();
    t_field();
    complete_run();
  end

  // The scenarios need under a thousand cycles, so this span only trips on a hang.
  initial
  begin
    repeat (20000) @(posedge core_clk);
    fails++;
    complete_run();
  end
endmodule
